// ---- rtl/isa_defs.svh ----
// Constants for the serial slave address recognition block
`ifndef ISA_DEFS_SVH
`define ISA_DEFS_SVH

// ==========================================================================
// Addressing
`define ISA_GLOBAL_ADDR 7'h73
`define ISA_ADDR_BASE_HI 3'h1
`define ISA_MAX_DATA_BYTES 3'h3
`define ISA_BITS_PER_BYTE 4'h8

// ==========================================================================
// Timing of the strap probe
`define ISA_CLK_MHZ 40
`define ISA_STRAP_DRV_NS 200
`define ISA_STRAP_SETTLE_NS 100
`define ISA_NS_TO_CYC(ns) ((((ns) * `ISA_CLK_MHZ) + 999) / 1000)
`define ISA_STRAP_DRV_CYC `ISA_NS_TO_CYC(`ISA_STRAP_DRV_NS)
`define ISA_STRAP_SETTLE_CYC `ISA_NS_TO_CYC(`ISA_STRAP_SETTLE_NS)

`endif

// ---- rtl/isa_pkg.sv ----
// Types for the serial slave address recognition block
package isa_pkg;

    // ======================================================================
    // Strap probe sequence
    typedef enum logic [2:0] {
        ISA_PRB_DRV_LO = 3'b000,
        ISA_PRB_REL_LO = 3'b001,
        ISA_PRB_DRV_HI = 3'b010,
        ISA_PRB_REL_HI = 3'b011,
        ISA_PRB_DONE = 3'b100
    } isa_prb_state_t;

    // Pin level read back as ternary: ground, float, supply
    typedef enum logic [1:0] {
        ISA_TRI_GND = 2'b00,
        ISA_TRI_FLOAT = 2'b01,
        ISA_TRI_VCC = 2'b10
    } isa_tri_t;

    // Drive pair for the three address-select pins
    typedef struct packed {
        logic [2:0] o;
        logic [2:0] oe;
    } isa_strap_drv_t;

endpackage

// ---- rtl/isa_slave.sv ----
// Serial slave address match and acknowledge with strap-pin address select
`timescale 1ns/1ps
`include "isa_defs.svh"

module isa_slave (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic scl_clk_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [2:0] addr_sel_pin_i,
    output isa_pkg::isa_strap_drv_t addr_sel_pin_o,
    output logic addr_ready_o
);
    import isa_pkg::*;

    localparam int DRV_CYC = `ISA_STRAP_DRV_CYC;
    localparam int SET_CYC = `ISA_STRAP_SETTLE_CYC;

    // ======================================================================
    // System domain: pin synchronisers
    logic [2:0] scl_sy_q, sda_sy_q;
    logic [2:0] sel_s1_q, sel_s2_q;
    always_ff @(posedge clk_i) begin
        scl_sy_q <= {scl_sy_q[1:0], scl_clk_i};
        sda_sy_q <= {sda_sy_q[1:0], sda_i};
        sel_s1_q <= addr_sel_pin_i;
        sel_s2_q <= sel_s1_q;
    end

    // START and STOP seen on settled samples only
    wire scl_hi = scl_sy_q[1] & scl_sy_q[2];
    wire start_det = scl_hi & sda_sy_q[2] & ~sda_sy_q[1];
    wire stop_det = scl_hi & ~sda_sy_q[2] & sda_sy_q[1];

    // Frame level and a clear pulse that spans the first clock fall
    logic start_lvl_q, in_frame_q, link_rst_q;
    always_ff @(posedge clk_i) begin
        link_rst_q <= ~nrst_i;
        if (!nrst_i) begin
            start_lvl_q <= 1'b0;
            in_frame_q <= 1'b0;
        end else begin
            start_lvl_q <= start_det | (start_lvl_q & scl_sy_q[1]);
            in_frame_q <= start_det | (in_frame_q & ~stop_det);
        end
    end

    // ======================================================================
    // Strap probe: drive low, release, sample; drive high, release, sample
    isa_prb_state_t prb_q;
    logic [7:0] prb_cnt_q;
    logic [2:0] smp_lo_q, smp_hi_q;
    isa_strap_drv_t drv_q;
    logic ready_q;
    logic [6:0] own_addr_q;
    logic [1:0] tri_w [3];
    logic [4:0] idx_w;
    wire prb_exp = (prb_cnt_q == 8'h00);

    // Floating pins keep the last level we forced, tied ones do not
    for (genvar g = 0; g < 3; g++) begin : g_tri
        assign tri_w[g] = (smp_lo_q[g] & smp_hi_q[g]) ? ISA_TRI_VCC :
                          (~smp_lo_q[g] & smp_hi_q[g]) ? ISA_TRI_FLOAT : ISA_TRI_GND;
    end
    assign idx_w = 5'(tri_w[2] * 9 + tri_w[1] * 3 + tri_w[0]);
    wire [6:0] map_addr = {3'(idx_w[4:2] + `ISA_ADDR_BASE_HI), 2'b00, idx_w[1:0]};

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            prb_q <= ISA_PRB_DRV_LO;
            prb_cnt_q <= 8'(DRV_CYC - 1);
            drv_q <= '{o: 3'h0, oe: 3'h7};
            smp_lo_q <= 3'h0;
            smp_hi_q <= 3'h0;
            ready_q <= 1'b0;
            own_addr_q <= 7'h00;
        end else begin
            prb_cnt_q <= prb_exp ? 8'h00 : prb_cnt_q - 8'h01;
            case (prb_q)
                ISA_PRB_DRV_LO: begin
                    if (prb_exp) begin
                        prb_q <= ISA_PRB_REL_LO;
                        prb_cnt_q <= 8'(SET_CYC - 1);
                        drv_q.oe <= 3'h0;
                    end
                end
                ISA_PRB_REL_LO: begin
                    if (prb_exp) begin
                        prb_q <= ISA_PRB_DRV_HI;
                        prb_cnt_q <= 8'(DRV_CYC - 1);
                        smp_lo_q <= sel_s2_q;
                        drv_q <= '{o: 3'h7, oe: 3'h7};
                    end
                end
                ISA_PRB_DRV_HI: begin
                    if (prb_exp) begin
                        prb_q <= ISA_PRB_REL_HI;
                        prb_cnt_q <= 8'(SET_CYC - 1);
                        drv_q.oe <= 3'h0;
                    end
                end
                ISA_PRB_REL_HI: begin
                    if (prb_exp) begin
                        prb_q <= ISA_PRB_DONE;
                        smp_hi_q <= sel_s2_q;
                    end
                end
                default: begin
                    // One cycle after the last sample so the map is settled
                    drv_q <= '{o: 3'h0, oe: 3'h0};
                    ready_q <= 1'b1;
                    own_addr_q <= map_addr;
                end
            endcase
        end
    end

    assign addr_sel_pin_o = drv_q;
    assign addr_ready_o = ready_q;

    // ======================================================================
    // Link domain: half-cycle synchronisers (fall then rise)
    logic clr_s1_q, clr_s2_q, frm_s1_q, frm_s2_q, rdy_s1_q, rdy_s2_q;
    always_ff @(negedge scl_clk_i or posedge link_rst_q) begin
        if (link_rst_q) begin
            clr_s1_q <= 1'b0;
            frm_s1_q <= 1'b0;
            rdy_s1_q <= 1'b0;
        end else begin
            clr_s1_q <= start_lvl_q;
            frm_s1_q <= in_frame_q;
            rdy_s1_q <= ready_q;
        end
    end

    // Bit capture on the rising clock edge
    logic [7:0] shreg_q;
    logic [3:0] bit_cnt_q;
    logic [2:0] byte_cnt_q;
    logic sel_q;
    wire ack_slot = (bit_cnt_q == `ISA_BITS_PER_BYTE);
    wire addr_hit = (shreg_q[7:1] == own_addr_q) | (shreg_q[7:1] == `ISA_GLOBAL_ADDR);
    wire addr_ok = rdy_s2_q & addr_hit & ~shreg_q[0];
    wire data_ok = sel_q & (byte_cnt_q != 3'h0) & (byte_cnt_q <= `ISA_MAX_DATA_BYTES);
    wire ack_ok = frm_s2_q & ((byte_cnt_q == 3'h0) ? addr_ok : data_ok);

    always_ff @(posedge scl_clk_i or posedge link_rst_q) begin
        if (link_rst_q) begin
            clr_s2_q <= 1'b0;
            frm_s2_q <= 1'b0;
            rdy_s2_q <= 1'b0;
            shreg_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            byte_cnt_q <= 3'h0;
            sel_q <= 1'b0;
        end else begin
            clr_s2_q <= clr_s1_q;
            frm_s2_q <= frm_s1_q;
            rdy_s2_q <= rdy_s1_q;
            if (clr_s1_q) begin
                // First rise after START carries the top address bit
                shreg_q <= {7'h00, sda_i};
                bit_cnt_q <= 4'h1;
                byte_cnt_q <= 3'h0;
                sel_q <= 1'b0;
            end else if (ack_slot) begin
                bit_cnt_q <= 4'h0;
                byte_cnt_q <= (byte_cnt_q == 3'h4) ? byte_cnt_q : byte_cnt_q + 3'h1;
                if (byte_cnt_q == 3'h0) begin
                    sel_q <= ack_ok;
                end
            end else begin
                shreg_q <= {shreg_q[6:0], sda_i};
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    // Acknowledge drive changes only on falls, so it is stable while clock is high
    logic ack_oe_q;
    always_ff @(negedge scl_clk_i or posedge link_rst_q) begin
        if (link_rst_q) begin
            ack_oe_q <= 1'b0;
        end else begin
            ack_oe_q <= ack_slot & ack_ok;
        end
    end

    assign sda_o = 1'b0; // Open drain: only ever pulls low
    assign sda_oe_o = ack_oe_q;

    // ======================================================================
    // Checks
    sequence s_addr_slot;
        ack_slot && byte_cnt_q == 3'h0 && frm_s2_q && rdy_s2_q;
    endsequence

    a_start_arms_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
        start_det |=> start_lvl_q && in_frame_q) else $error("START not taken");
    a_stop_ends_frame: assert property (@(posedge clk_i) disable iff (!nrst_i)
        stop_det && !start_det |=> !in_frame_q) else $error("STOP not taken");
    a_addr_mid_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ready_q |-> own_addr_q[3:2] == 2'b00) else $error("A3/A2 not zero");
    a_strap_drive_probe: assert property (@(posedge clk_i) disable iff (!nrst_i)
        prb_q == ISA_PRB_REL_LO && prb_exp |=> drv_q.oe == 3'h7 && drv_q.o == 3'h7)
        else $error("Probe did not drive high");
    // Ternary digit is low sample plus high sample; rebuilt apart from the map logic
    a_strap_map: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(ready_q) |-> int'(own_addr_q[6:4]) * 4 + int'(own_addr_q[1:0]) - 4 ==
        9 * (smp_lo_q[2] + smp_hi_q[2]) + 3 * (smp_lo_q[1] + smp_hi_q[1]) +
        (smp_lo_q[0] + smp_hi_q[0]))
        else $error("Address map wrong");
    a_write_acked: assert property (@(negedge scl_clk_i) disable iff (link_rst_q)
        s_addr_slot ##0 (addr_hit && !shreg_q[0]) |=> sda_oe_o)
        else $error("Write address not acked");
    a_global_acked: assert property (@(negedge scl_clk_i) disable iff (link_rst_q)
        s_addr_slot ##0 (shreg_q == {`ISA_GLOBAL_ADDR, 1'b0}) |=> sda_oe_o)
        else $error("Global address not acked");
    a_read_refused: assert property (@(negedge scl_clk_i) disable iff (link_rst_q)
        ack_slot && byte_cnt_q == 3'h0 && shreg_q[0] |=> !sda_oe_o)
        else $error("Read acked");
    a_extra_nack: assert property (@(negedge scl_clk_i) disable iff (link_rst_q)
        ack_slot && byte_cnt_q == 3'h4 |=> !sda_oe_o) else $error("Fourth byte acked");
    a_ack_held_high: assert property (@(posedge scl_clk_i) disable iff (link_rst_q)
        ack_slot && !clr_s1_q |-> sda_oe_o == ack_ok) else $error("Ack not stable");
    // Clear pulse must be gone by the second rise, or bit two would reload the shifter
    a_start_clear_once: assert property (@(posedge scl_clk_i) disable iff (link_rst_q)
        clr_s2_q |-> !clr_s1_q) else $error("Start clear held past first bit");
    a_oe_released: assert property (@(negedge scl_clk_i) disable iff (link_rst_q)
        !ack_slot |=> !sda_oe_o) else $error("Data line held outside ack");

endmodule

// ---- testbench/isa_master_model.sv ----
// Two-wire bus master model driving the serial clock and data lines
`timescale 1ns/1ps
module isa_master_model (
    output logic scl_o,
    output logic sda_lo_o,
    input wire logic sda_i
);
    // ======
    // Bus idle: both lines released, clock stands still between frames
    initial begin
        scl_o = 1'b1;
        sda_lo_o = 1'b0;
    end
    // Start or repeated start, held long enough for the sampling domain
    task automatic start();
        sda_lo_o = 1'b0;
        #20 scl_o = 1'b1;
        #40 sda_lo_o = 1'b1;
        #120 scl_o = 1'b0;
        #60;
    endtask
    // Stop: data rises while clock is high
    task automatic stop();
        sda_lo_o = 1'b1;
        #20 scl_o = 1'b1;
        #40 sda_lo_o = 1'b0;
        #120;
    endtask
    // Byte MSB first; ack is 0 or 1 only if the two samples near the start and end of the high agree
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s1;
        logic s2;
        for (int i = 7; i >= 0; i--) begin
            sda_lo_o = ~b[i];
            #20 scl_o = 1'b1;
            #40 scl_o = 1'b0;
            #20;
        end
        sda_lo_o = 1'b0;
        #20 scl_o = 1'b1;
        #2 s1 = sda_i;
        #36 s2 = sda_i;
        #2 scl_o = 1'b0;
        ack = (s1 === s2) ? s1 : 1'bx;
        #20;
    endtask
endmodule

// ---- testbench/isa_slave_tb_top.sv ----
// Self-checking bench for the serial slave address match and acknowledge
`timescale 1ns/1ps
module isa_slave_tb_top;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic scl_clk_i;
    logic sda_lo;
    logic sda_o;
    logic sda_oe_o;
    logic [2:0] pin = 3'h0;
    logic [5:0] st = 6'h0;
    isa_pkg::isa_strap_drv_t pin_drv;
    logic addr_ready_o;
    logic [6:0] own;
    int fails = 0;
    int compares = 0;
    // Pull-up wins unless a party pulls low
    wire sda = ~(sda_lo | (sda_oe_o & ~sda_o));

    always #12.5 clk_i = ~clk_i;

    // Tied straps win; a floating pin keeps its last forced level
    always @* begin
        for (int k = 0; k < 3; k++) begin
            if (st[2*k+:2] == 2'h0) pin[k] = 1'b0;
            else if (st[2*k+:2] == 2'h2) pin[k] = 1'b1;
            else if (pin_drv.oe[k]) pin[k] = pin_drv.o[k];
        end
    end

    isa_master_model m (.scl_o(scl_clk_i), .sda_lo_o(sda_lo), .sda_i(sda));
    isa_slave dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .scl_clk_i(scl_clk_i), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_sel_pin_i(pin),
        .addr_sel_pin_o(pin_drv), .addr_ready_o(addr_ready_o)
    );

    // ======
    // Helpers
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Straps change only under reset, since the probe runs once per reset
    task automatic strap_reset(input int idx);
        logic rel;
        rel = 1'b0;
        @(posedge clk_i);
        #2 nrst_i = 1'b0;
        st = {2'(idx / 9), 2'((idx / 3) % 3), 2'(idx % 3)};
        own = {3'(idx / 4 + 1), 2'b00, 2'(idx % 4)};
        repeat (20) @(posedge clk_i);
        #2 chk("probe oe", 8'h07, 8'(pin_drv.oe));
        nrst_i = 1'b1;
        for (int i = 0; i < 100 && addr_ready_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #2;
            if (pin_drv.oe === 3'h0) rel = 1'b1;
        end
        chk("ready", 8'h01, 8'(addr_ready_o));
        chk("probe released", 8'h01, 8'(rel));
    endtask
    // Address byte then nd data bytes; bit k of nack is the expected ack level
    task automatic frame(input logic [7:0] b0, input int nd, input logic [7:0] nack,
                         input bit stp);
        logic a;
        m.start();
        m.put_byte(b0, a);
        chk("addr ack", 8'(nack[0]), 8'(a));
        for (int k = 1; k <= nd; k++) begin
            m.put_byte(8'hA5 ^ 8'(k * 60), a);
            chk("data ack", 8'(nack[k]), 8'(a));
        end
        if (stp) m.stop();
    endtask

    // ======
    // Scenarios
    task automatic sc_own();
        int idx[3] = '{0, 13, 26};
        foreach (idx[j]) begin
            strap_reset(idx[j]);
            frame({own, 1'b0}, 4, 8'h10, 1'b1);
        end
    endtask
    // Global address acts as own address whatever the straps say
    task automatic sc_global();
        frame({7'h73, 1'b0}, 4, 8'h10, 1'b1);
        strap_reset(5);
        frame({7'h73, 1'b0}, 3, 8'h00, 1'b1);
    endtask
    task automatic sc_read();
        frame({own, 1'b1}, 0, 8'h01, 1'b1);
        frame({7'h73, 1'b1}, 0, 8'h01, 1'b1);
    endtask
    // Foreign address refused; a repeated start rearms the byte count
    task automatic sc_restart();
        frame({own ^ 7'h01, 1'b0}, 1, 8'h03, 1'b1);
        frame({own, 1'b0}, 2, 8'h00, 1'b0);
        frame({own, 1'b0}, 4, 8'h10, 1'b1);
    endtask

    task automatic final_report();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        sc_own();
        sc_global();
        sc_read();
        sc_restart();
        final_report();
    end
    // Watchdog: about ten times the expected run
    initial begin
        #400000;
        fails++;
        $display("[ERR] watchdog expected finish seen timeout");
        final_report();
    end
endmodule
